// file: hdl/bls_pkg.sv
// Constants, register map and delay table of the backlight sequencer
package bls_pkg;
   // ==========================================
   // Register offsets
   localparam logic [7:0] OFS_POWER_CTRL = 8'h00;
   localparam logic [7:0] OFS_LEVEL_CURVE = 8'h02;
   localparam logic [7:0] OFS_DELAYS = 8'h03;
   localparam logic [7:0] OFS_SUNLIT_PEAK = 8'h05;
   localparam logic [7:0] OFS_SUNLIT_LOW = 8'h06;
   localparam logic [7:0] OFS_INDOOR_PEAK = 8'h07;
   localparam logic [7:0] OFS_INDOOR_LOW = 8'h08;
   localparam logic [7:0] OFS_NIGHT_PEAK = 8'h09;
   localparam logic [7:0] OFS_NIGHT_LOW = 8'h0a;
   // ==========================================
   // Field positions
   localparam int POS_STANDBY_N = 0;
   localparam int POS_ON_REQ = 1;
   localparam int POS_DIM_REQ = 2;
   localparam int POS_LEVEL = 0;
   localparam int POS_CURVE = 4;
   localparam int POS_AUTO = 6;
   localparam int POS_DIM_DLY = 0;
   localparam int POS_OFF_DLY = 4;
   // ==========================================
   // Encodings and reset values
   localparam logic [1:0] LVL_DAYLIGHT = 2'h0;
   localparam logic [1:0] LVL_OFFICE = 2'h1;
   localparam logic [1:0] LVL_DARK = 2'h2;
   localparam logic [1:0] CURVE_LINEAR = 2'h0;
   localparam logic [1:0] CURVE_SQUARE = 2'h1;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [6:0] CODE_FULL = 7'h7f;
   localparam logic [3:0] DLY_DISABLED = 4'h0;
   // ==========================================
   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int ONE_SEC_NS = 1000000000;
   localparam int SEC_CYC = ONE_SEC_NS / CLK_PERIOD_NS;
   localparam int FADE_STEP_NS = 4;
   localparam int FADE_STEP_CYC =
      (FADE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      BLS_OFF = 3'h1,
      BLS_MAX = 3'h2,
      BLS_DIM = 3'h4
   } bls_state_e;

   // Delay setting to seconds; zero means the timer is unused
   function automatic logic [6:0] bls_delay_sec(input logic [3:0] sel);
      logic [6:0] s;
      s = 7'h00;
      case (sel)
         4'h1: s = 7'd10;
         4'h2: s = 7'd18;
         4'h3: s = 7'd26;
         4'h4: s = 7'd34;
         4'h5: s = 7'd42;
         4'h6: s = 7'd50;
         4'h7: s = 7'd58;
         4'h8: s = 7'd66;
         4'h9: s = 7'd74;
         4'ha: s = 7'd82;
         4'hb: s = 7'd90;
         4'hc: s = 7'd98;
         4'hd: s = 7'd106;
         4'he: s = 7'd114;
         4'hf: s = 7'd120;
         default: s = 7'h00;
      endcase
      return s;
   endfunction : bls_delay_sec
endpackage : bls_pkg

// file: hdl/bls_curve_map.sv
// Code to sink current law, in units of full scale / 16129
module bls_curve_map (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [6:0] code,
   input wire logic [1:0] curve,
   output logic [13:0] level
);
   logic [13:0] level_d;
   logic [13:0] level_q;

   // ==========================================
   // Mapping
   always_comb begin
      // linear law, code x full / 127
      level_d = 14'(code) * 14'(bls_pkg::CODE_FULL);
      // square law; curve codes 2 and 3 reuse it
      if (curve != bls_pkg::CURVE_LINEAR) begin
         level_d = 14'(code) * 14'(code);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         level_q <= 14'h0000;
      end else begin
         level_q <= level_d;
      end
   end

   assign level = level_q;

   a_linear_law: assert property (@(posedge clk) disable iff (!rst_n)
      curve == bls_pkg::CURVE_LINEAR |=> level == 14'($past(code) * 127))
      else $error("linear law output wrong");
   a_square_law: assert property (@(posedge clk) disable iff (!rst_n)
      curve == bls_pkg::CURVE_SQUARE |=>
      level == 14'($past(code)) * 14'($past(code)))
      else $error("square law output wrong");
endmodule : bls_curve_map

// file: hdl/bls_sequencer.sv
// Backlight level, dim and off sequencer with register port
module bls_sequencer #(
   parameter int SEC_CYC = bls_pkg::SEC_CYC,
   parameter int FADE_CYC = bls_pkg::FADE_STEP_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] ambient_level,
   output logic [6:0] sink_code,
   output logic [13:0] sink_level,
   output logic backlight_active
);
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] lvlcfg_q, lvlcfg_d;
   logic [7:0] dly_q, dly_d;
   logic [6:0] code_q [6];
   logic [6:0] code_d [6];
   logic [7:0] rdata_q, rdata_d;
   logic [31:0] pre_q, pre_d;
   logic [6:0] dim_sec_q, dim_sec_d;
   logic [6:0] off_sec_q, off_sec_d;
   logic [31:0] fade_q, fade_d;
   logic [6:0] disp_q, disp_d;
   bls_pkg::bls_state_e st_q, st_d;

   logic wr_ctrl, reassert, on_eff, sec_tick, dim_exp, off_exp;
   logic [6:0] dim_lim, off_lim, target;
   logic [1:0] lvl;
   logic [2:0] sel;

   assign lvl = lvlcfg_q[bls_pkg::POS_LEVEL +: 2];
   assign wr_ctrl = reg_wr && reg_addr == bls_pkg::OFS_POWER_CTRL;
   assign reassert = wr_ctrl && reg_wdata[bls_pkg::POS_ON_REQ];
   // request honoured only in normal mode
   assign on_eff = ctrl_q[bls_pkg::POS_ON_REQ]
      && ctrl_q[bls_pkg::POS_STANDBY_N];
   assign dim_lim = bls_pkg::bls_delay_sec(dly_q[bls_pkg::POS_DIM_DLY +: 4]);
   assign off_lim = bls_pkg::bls_delay_sec(dly_q[bls_pkg::POS_OFF_DLY +: 4]);
   assign sec_tick = pre_q == 32'(SEC_CYC - 1);
   assign dim_exp = on_eff && !ctrl_q[bls_pkg::POS_DIM_REQ] && !reassert
      && dim_lim != 7'h00 && sec_tick && dim_sec_q == dim_lim - 7'h01;
   assign off_exp = on_eff && !reassert && off_lim != 7'h00
      && sec_tick && off_sec_q == off_lim - 7'h01;

   // ==========================================
   // Register file
   always_comb begin
      ctrl_d = ctrl_q;
      lvlcfg_d = lvlcfg_q;
      dly_d = dly_q;
      code_d = code_q;
      rdata_d = 8'h00;
      if (reg_wr) begin
         if (reg_addr == bls_pkg::OFS_POWER_CTRL) begin
            ctrl_d = {5'h00, reg_wdata[2:0]};
         end else if (reg_addr == bls_pkg::OFS_LEVEL_CURVE) begin
            // host owns the level unless in auto mode
            lvlcfg_d = {1'b0, reg_wdata[6:0]};
            if (lvlcfg_q[bls_pkg::POS_AUTO]) begin
               lvlcfg_d[bls_pkg::POS_LEVEL +: 2] = lvl;
            end
         end else if (reg_addr == bls_pkg::OFS_DELAYS) begin
            dly_d = reg_wdata;
         end else if (reg_addr >= bls_pkg::OFS_SUNLIT_PEAK
               && reg_addr <= bls_pkg::OFS_NIGHT_LOW) begin
            // seven-bit codes, top bit reads zero
            code_d[3'(reg_addr - bls_pkg::OFS_SUNLIT_PEAK)] = reg_wdata[6:0];
         end
      end
      // ambient logic drives the level in auto mode, except when it reads 11
      if (lvlcfg_q[bls_pkg::POS_AUTO] && ambient_level != 2'h3) begin
         lvlcfg_d[bls_pkg::POS_LEVEL +: 2] = ambient_level;
      end
      // dim timer expiry sets dim request, loses to a reassert
      if (dim_exp) begin
         ctrl_d[bls_pkg::POS_DIM_REQ] = 1'b1;
      end
      // off timer expiry clears on request unless rewritten
      if (off_exp) begin
         ctrl_d[bls_pkg::POS_ON_REQ] = 1'b0;
      end
      if (reg_rd) begin
         if (reg_addr == bls_pkg::OFS_POWER_CTRL) begin
            rdata_d = ctrl_q;
         end else if (reg_addr == bls_pkg::OFS_LEVEL_CURVE) begin
            rdata_d = lvlcfg_q;
         end else if (reg_addr == bls_pkg::OFS_DELAYS) begin
            rdata_d = dly_q;
         end else if (reg_addr >= bls_pkg::OFS_SUNLIT_PEAK
               && reg_addr <= bls_pkg::OFS_NIGHT_LOW) begin
            rdata_d = {1'b0, code_q[3'(reg_addr - bls_pkg::OFS_SUNLIT_PEAK)]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= bls_pkg::RST_REG;
         lvlcfg_q <= bls_pkg::RST_REG;
         dly_q <= bls_pkg::RST_REG;
         rdata_q <= bls_pkg::RST_REG;
      end else begin
         ctrl_q <= ctrl_d;
         lvlcfg_q <= lvlcfg_d;
         dly_q <= dly_d;
         rdata_q <= rdata_d;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_code
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               code_q[gi] <= 7'h00;
            end else begin
               code_q[gi] <= code_d[gi];
            end
         end
      end
   endgenerate

   // ==========================================
   // Sequencer state and timers
   always_comb begin
      // on bit drives the backlight, clear turns it off
      st_d = bls_pkg::BLS_OFF;
      if (on_eff) begin
         st_d = ctrl_q[bls_pkg::POS_DIM_REQ] ? bls_pkg::BLS_DIM
            : bls_pkg::BLS_MAX;
      end
      pre_d = (!on_eff || sec_tick) ? 32'h0 : pre_q + 32'h1;
      dim_sec_d = dim_sec_q;
      off_sec_d = off_sec_q;
      if (sec_tick) begin
         dim_sec_d = dim_sec_q + 7'h01;
         off_sec_d = off_sec_q + 7'h01;
      end
      // dim clear or reassert restarts the dim count
      // reassert during dim count restarts it
      if (!on_eff || ctrl_q[bls_pkg::POS_DIM_REQ] || reassert || dim_exp) begin
         dim_sec_d = 7'h00;
      end
      // reassert during off count restarts it
      if (!on_eff || reassert || off_exp) begin
         off_sec_d = 7'h00;
      end
      if (reassert) begin
         pre_d = 32'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= bls_pkg::BLS_OFF;
         pre_q <= 32'h0;
         dim_sec_q <= 7'h00;
         off_sec_q <= 7'h00;
      end else begin
         st_q <= st_d;
         pre_q <= pre_d;
         dim_sec_q <= dim_sec_d;
         off_sec_q <= off_sec_d;
      end
   end

   // ==========================================
   // Target code and fading
   // level picks the code pair; 11 falls back to dark
   // level change retargets the live state at once
   always_comb begin
      sel = 3'h4;
      if (lvl == bls_pkg::LVL_DAYLIGHT) begin
         sel = 3'h0;
      end else if (lvl == bls_pkg::LVL_OFFICE) begin
         sel = 3'h2;
      end
      // dim code taken as is, no clamp against max
      target = 7'h00;
      case (st_q)
         bls_pkg::BLS_MAX: target = code_q[sel];
         bls_pkg::BLS_DIM: target = code_q[sel + 3'h1];
         default: target = 7'h00;
      endcase
   end

   // one code step per fade interval toward target
   always_comb begin
      fade_d = fade_q + 32'h1;
      disp_d = disp_q;
      if (fade_q >= 32'(FADE_CYC - 1)) begin
         fade_d = 32'h0;
         if (disp_q < target) begin
            disp_d = disp_q + 7'h01;
         end else if (disp_q > target) begin
            disp_d = disp_q - 7'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fade_q <= 32'h0;
         disp_q <= 7'h00;
      end else begin
         fade_q <= fade_d;
         disp_q <= disp_d;
      end
   end

   bls_curve_map u_map (
      .clk(clk),
      .rst_n(rst_n),
      .code(disp_q),
      .curve(lvlcfg_q[bls_pkg::POS_CURVE +: 2]),
      .level(sink_level)
   );

   assign sink_code = disp_q;
   assign reg_rdata = rdata_q;
   assign backlight_active = st_q != bls_pkg::BLS_OFF;

   // ==========================================
   // Checks
   sequence s_dim_expire;
      dim_exp && !off_exp && !wr_ctrl;
   endsequence
   sequence s_dim_set;
      ctrl_q[bls_pkg::POS_DIM_REQ] ##1 st_q == bls_pkg::BLS_DIM;
   endsequence

   a_dim_expiry: assert property (@(posedge clk) disable iff (!rst_n)
      s_dim_expire |=> s_dim_set)
      else $error("dim expiry did not dim");
   a_off_expiry: assert property (@(posedge clk) disable iff (!rst_n)
      off_exp |=> !ctrl_q[bls_pkg::POS_ON_REQ] ##1 st_q == bls_pkg::BLS_OFF)
      else $error("off expiry did not turn off");
   a_standby_gate: assert property (@(posedge clk) disable iff (!rst_n)
      !ctrl_q[bls_pkg::POS_STANDBY_N] |=> st_q == bls_pkg::BLS_OFF)
      else $error("backlight on in standby");
   a_on_follows: assert property (@(posedge clk) disable iff (!rst_n)
      on_eff && !ctrl_q[bls_pkg::POS_DIM_REQ] |=> st_q == bls_pkg::BLS_MAX)
      else $error("on request not followed");
   a_dim_restart: assert property (@(posedge clk) disable iff (!rst_n)
      reassert |=> dim_sec_q == 7'h00 && off_sec_q == 7'h00 && pre_q == 32'h0)
      else $error("reassert did not restart timers");
   a_dly_disable: assert property (@(posedge clk) disable iff (!rst_n)
      dim_lim == 7'h00 && !wr_ctrl |=> $stable(ctrl_q[bls_pkg::POS_DIM_REQ]))
      else $error("disabled dim timer expired");
   a_level_target: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == bls_pkg::BLS_MAX && lvl == bls_pkg::LVL_OFFICE
      |-> target == code_q[2])
      else $error("office max code not used");
   a_dark_dim: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == bls_pkg::BLS_DIM && lvl == bls_pkg::LVL_DARK
      |-> target == code_q[5])
      else $error("dark dim code not used");
   a_fade_step: assert property (@(posedge clk) disable iff (!rst_n)
      disp_q != target |-> ##[1:2] disp_q != $past(disp_q, 2)
      || target == $past(disp_q, 2))
      else $error("fade did not step");
endmodule : bls_sequencer

// file: tb/tb.sv
// Self-checking bench for the backlight level sequencer
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ======================================================
   // Clock, reset, stimulus signals
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [1:0] ambient_level = 2'h2;
   logic [6:0] sink_code;
   logic [13:0] sink_level;
   logic backlight_active;
   logic [7:0] v;
   int errors = 0;
   int n_compared = 0;
   // Short second so the delay table fits a short run
   localparam int SEC = 10;

   always #2 clk = ~clk;

   bls_sequencer #(.SEC_CYC(SEC), .FADE_CYC(1)) dut (
      .clk(clk),
      .rst_n(rst_n),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .ambient_level(ambient_level),
      .sink_code(sink_code),
      .sink_level(sink_level),
      .backlight_active(backlight_active)
   );

`define CHK(got, exp) begin \
   n_compared++; \
   if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
   end \
end

   // ======================================================
   // Register access and waits
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   // Fade runs one step a cycle, so 400 cycles covers any ramp
   task automatic wait_code(input logic [6:0] exp);
      int i;
      for (i = 0; i < 400; i++) begin
         @(posedge clk);
         #1;
         if (sink_code === exp) break;
      end
      `CHK(sink_code, exp)
   endtask : wait_code

   task automatic close_out();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      #400000;
      errors++;
      close_out();
   end

   // ======================================================
   // Main sequence
   initial begin
      logic [7:0] ofs [6];
      logic [7:0] cod [6];
      logic [6:0] dimc [4];
      int k;
      ofs = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a};
      cod = '{8'h40, 8'h50, 8'h20, 8'h10, 8'h7f, 8'hff};
      dimc = '{7'h50, 7'h10, 7'h7f, 7'h7f};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, unmapped place reads zero
      foreach (ofs[k]) begin
         rd(ofs[k]);
         `CHK(v, 8'h00)
      end
      rd(bls_pkg::OFS_LEVEL_CURVE);
      `CHK(v, 8'h00)
      wr(8'h01, 8'haa);
      rd(8'h01);
      `CHK(v, 8'h00)
      // Codes hold seven bits only
      foreach (ofs[k]) wr(ofs[k], cod[k]);
      foreach (ofs[k]) begin
         rd(ofs[k]);
         `CHK(v, cod[k] & 8'h7f)
      end
      // On request ignored in standby
      wr(bls_pkg::OFS_POWER_CTRL, 8'h02);
      repeat (6) @(posedge clk);
      `CHK(backlight_active, 1'b0)
      `CHK(sink_code, 7'h00)
      wr(bls_pkg::OFS_POWER_CTRL, 8'h03);
      wait_code(7'h40);
      repeat (2) @(posedge clk);
      `CHK(backlight_active, 1'b1)
      `CHK(sink_level, 14'd8128)
      // Dim above max is not clamped
      wr(bls_pkg::OFS_POWER_CTRL, 8'h07);
      wait_code(7'h50);
      // Level change follows active dim state
      for (k = 1; k < 4; k++) begin
         wr(bls_pkg::OFS_LEVEL_CURVE, k[7:0]);
         wait_code(dimc[k]);
      end
      wr(bls_pkg::OFS_LEVEL_CURVE, 8'h10);
      wait_code(7'h50);
      repeat (2) @(posedge clk);
      `CHK(sink_level, 14'd6400)
      // Zero delay settings leave the state alone
      repeat (300) @(posedge clk);
      rd(bls_pkg::OFS_POWER_CTRL);
      `CHK(v, 8'h07)
      // Ambient input only counts in auto mode
      wr(bls_pkg::OFS_LEVEL_CURVE, 8'h40);
      wait_code(7'h7f);
      ambient_level <= 2'h1;
      wait_code(7'h10);
      wr(bls_pkg::OFS_LEVEL_CURVE, 8'h00);
      wr(bls_pkg::OFS_LEVEL_CURVE, 8'h00);
      wait_code(7'h50);
      wr(bls_pkg::OFS_POWER_CTRL, 8'h03);
      wait_code(7'h40);
      wr(bls_pkg::OFS_POWER_CTRL, 8'h01);
      wait_code(7'h00);
      `CHK(backlight_active, 1'b0)
      // Dim at 10 s, off at 18 s
      wr(bls_pkg::OFS_DELAYS, 8'h21);
      rd(bls_pkg::OFS_DELAYS);
      `CHK(v, 8'h21)
      wr(bls_pkg::OFS_POWER_CTRL, 8'h03);
      repeat (85) @(posedge clk);
      rd(bls_pkg::OFS_POWER_CTRL);
      `CHK(v, 8'h03)
      repeat (20) @(posedge clk);
      rd(bls_pkg::OFS_POWER_CTRL);
      `CHK(v, 8'h07)
      wait_code(7'h50);
      repeat (60) @(posedge clk);
      rd(bls_pkg::OFS_POWER_CTRL);
      `CHK(v & 8'h02, 8'h02)
      repeat (20) @(posedge clk);
      rd(bls_pkg::OFS_POWER_CTRL);
      `CHK(v & 8'h02, 8'h00)
      wait_code(7'h00);
      `CHK(backlight_active, 1'b0)
      // Reassert mid count restarts it
      wr(bls_pkg::OFS_POWER_CTRL, 8'h03);
      repeat (60) @(posedge clk);
      wr(bls_pkg::OFS_POWER_CTRL, 8'h03);
      repeat (85) @(posedge clk);
      rd(bls_pkg::OFS_POWER_CTRL);
      `CHK(v, 8'h03)
      repeat (20) @(posedge clk);
      rd(bls_pkg::OFS_POWER_CTRL);
      `CHK(v, 8'h07)
      // Old off count would have ended by now
      repeat (10) @(posedge clk);
      rd(bls_pkg::OFS_POWER_CTRL);
      `CHK(v & 8'h02, 8'h02)
      wr(bls_pkg::OFS_POWER_CTRL, 8'h01);
      repeat (3) @(posedge clk);
      `CHK(backlight_active, 1'b0)
      wait_code(7'h00);
      close_out();
   end
endmodule : tb
